// ### rtl/pio_pkg.sv
// Behaviour
// - While an enabled peripheral actively drives a pin, the port driver for that bit is off but the pin still reads back.
// - When a peripheral is enabled but not driving a pin, the port logic may drive that pin.
// - A direction bit of one makes the pin an input and zero makes it an output.
// - Every reset sets all implemented direction bits so all pins start as inputs.
// - Reading the output latch register returns the latch contents and writing it updates the latch.
// - Reading the pin level register returns the pin states and writing it writes the output latch.
// - Unimplemented bits are disabled and read as zero in latch, direction and pin level.
// - A pin shared only with an input-only function behaves as a dedicated port pin.
// - Output data and output enable of each pad pass a multiplexer pair where the peripheral wins.
// - Pins selected as analog inputs read as zero in the pin level register.
// - Pins configured as digital inputs are not presented to the converter.
package pio_pkg;
  localparam int unsigned PORT_WIDTH = 16;
  localparam int unsigned ADDR_WIDTH = 4;
  localparam logic [ADDR_WIDTH-1:0] DIR_OFFSET = 4'h0;
  localparam logic [ADDR_WIDTH-1:0] LEVEL_OFFSET = 4'h4;
  localparam logic [ADDR_WIDTH-1:0] LATCH_OFFSET = 4'h8;
  localparam logic [ADDR_WIDTH-1:0] ANALOG_OFFSET = 4'hc;
  localparam logic [PORT_WIDTH-1:0] DIR_RESET = 16'hffff;
  localparam logic [PORT_WIDTH-1:0] LATCH_RESET = 16'h0000;
  localparam logic [PORT_WIDTH-1:0] ANALOG_RESET = 16'h0000;
  localparam logic [PORT_WIDTH-1:0] IMPL_MASK_DEFAULT = 16'h0fff;
  localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage

// ### rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // A level change counts only once the second and third stages agree.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      sync_out <= (stage2 & stage3) | (sync_out & (stage2 | stage3));
    end
  end
endmodule

// ### rtl/pad_mux.sv
`timescale 1ns/1ps
module pad_mux (
  // Peripheral side
  input wire logic periph_enable,
  input wire logic periph_drive,
  input wire logic periph_data,
  // Port side
  input wire logic port_data,
  input wire logic port_dir_in,
  // Pad side
  output logic pad_data,
  output logic pad_oe
);
  logic periph_owns;

  assign periph_owns = periph_enable & periph_drive;
  assign pad_data = periph_owns ? periph_data : port_data;
  assign pad_oe = periph_owns ? 1'b1 : ~port_dir_in;
endmodule

// ### rtl/shared_parallel_io_port.sv
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module shared_parallel_io_port #(
  parameter int unsigned WIDTH = pio_pkg::PORT_WIDTH,
  parameter logic [pio_pkg::PORT_WIDTH-1:0] IMPL_MASK = pio_pkg::IMPL_MASK_DEFAULT,
  parameter logic [pio_pkg::PORT_WIDTH-1:0] ANALOG_CAPABLE = 16'h00ff
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [pio_pkg::ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Peripherals sharing the pins
  input wire logic [pio_pkg::PORT_WIDTH-1:0] periph_enable,
  input wire logic [pio_pkg::PORT_WIDTH-1:0] periph_drive,
  input wire logic [pio_pkg::PORT_WIDTH-1:0] periph_data,
  output logic [pio_pkg::PORT_WIDTH-1:0] periph_in,
  // Pads
  input wire logic [pio_pkg::PORT_WIDTH-1:0] pad_in,
  output logic [pio_pkg::PORT_WIDTH-1:0] pad_out,
  output logic [pio_pkg::PORT_WIDTH-1:0] pad_oe,
  // Converter
  output logic [pio_pkg::PORT_WIDTH-1:0] analog_input_pins
);
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_DONE = 2'b01
  } bus_state_e;

  bus_state_e bus_state;
  logic [pio_pkg::PORT_WIDTH-1:0] pin_direction_reg;
  logic [pio_pkg::PORT_WIDTH-1:0] output_latch_reg;
  logic [pio_pkg::PORT_WIDTH-1:0] analog_pin_select_reg;
  logic [pio_pkg::PORT_WIDTH-1:0] pin_level_reg;
  logic [pio_pkg::PORT_WIDTH-1:0] pad_sync;
  logic [pio_pkg::PORT_WIDTH-1:0] mux_data;
  logic [pio_pkg::PORT_WIDTH-1:0] mux_oe;
  logic [pio_pkg::PORT_WIDTH-1:0] wmask;
  logic [pio_pkg::PORT_WIDTH-1:0] wdata;
  logic [31:0] next_readdata;
  logic access;
  logic take;

  assign access = avs_read | avs_write;
  // One wait cycle per access; the request is taken when waitrequest is low.
  assign take = access & (bus_state == BUS_DONE);
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & IMPL_MASK;
  assign wdata = avs_writedata[pio_pkg::PORT_WIDTH-1:0];

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_state <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      case (bus_state)
        BUS_IDLE:
        begin
          if (access)
          begin
            bus_state <= BUS_DONE;
            avs_waitrequest <= 1'b0;
          end
        end
        BUS_DONE:
        begin
          bus_state <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default:
        begin
          bus_state <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Direction register; all implemented pins come up as inputs.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      pin_direction_reg <= pio_pkg::DIR_RESET & IMPL_MASK;
    else if (take && avs_write && avs_address == pio_pkg::DIR_OFFSET)
      pin_direction_reg <= (pin_direction_reg & ~wmask) | (wdata & wmask);
  end

  // Writes to either the latch or the pin level address land in the latch.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      output_latch_reg <= pio_pkg::LATCH_RESET;
    else if (take && avs_write && (avs_address == pio_pkg::LATCH_OFFSET ||
             avs_address == pio_pkg::LEVEL_OFFSET))
      output_latch_reg <= (output_latch_reg & ~wmask) | (wdata & wmask);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      analog_pin_select_reg <= pio_pkg::ANALOG_RESET;
    else if (take && avs_write && avs_address == pio_pkg::ANALOG_OFFSET)
      analog_pin_select_reg <= (analog_pin_select_reg & ~wmask) |
                               (wdata & wmask & ANALOG_CAPABLE & IMPL_MASK);
  end

  pin_sync #(
    .WIDTH(pio_pkg::PORT_WIDTH)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .async_in(pad_in),
    .sync_out(pad_sync)
  );

  // Analog pins read zero; unimplemented bits read zero.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      pin_level_reg <= '0;
    else
      pin_level_reg <= pad_sync & ~analog_pin_select_reg & IMPL_MASK;
  end

  always_comb
  begin
    next_readdata = pio_pkg::UNMAPPED_DATA;
    case (avs_address)
      pio_pkg::DIR_OFFSET: next_readdata[pio_pkg::PORT_WIDTH-1:0] = pin_direction_reg;
      pio_pkg::LEVEL_OFFSET: next_readdata[pio_pkg::PORT_WIDTH-1:0] = pin_level_reg;
      pio_pkg::LATCH_OFFSET: next_readdata[pio_pkg::PORT_WIDTH-1:0] = output_latch_reg;
      pio_pkg::ANALOG_OFFSET: next_readdata[pio_pkg::PORT_WIDTH-1:0] = analog_pin_select_reg;
      default: next_readdata = pio_pkg::UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      avs_readdata <= pio_pkg::UNMAPPED_DATA;
    else if (avs_read && bus_state == BUS_IDLE)
      avs_readdata <= next_readdata;
  end

  // An input-only sharer never asserts periph_drive, so the port keeps the pin.
  genvar gi;
  generate
    for (gi = 0; gi < pio_pkg::PORT_WIDTH; gi++)
    begin : g_pad
      pad_mux u_pad_mux (
        .periph_enable(periph_enable[gi]),
        .periph_drive(periph_drive[gi]),
        .periph_data(periph_data[gi]),
        .port_data(output_latch_reg[gi]),
        .port_dir_in(pin_direction_reg[gi]),
        .pad_data(mux_data[gi]),
        .pad_oe(mux_oe[gi])
      );
    end
  endgenerate

  // Pad outputs are registered so unimplemented bits stay quiet.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pad_out <= '0;
      pad_oe <= '0;
      periph_in <= '0;
      analog_input_pins <= '0;
    end
    else
    begin
      pad_out <= mux_data & IMPL_MASK;
      pad_oe <= mux_oe & IMPL_MASK;
      periph_in <= pad_sync & IMPL_MASK;
      analog_input_pins <= analog_pin_select_reg & IMPL_MASK;
    end
  end

  AST_DIR_RESET: assert property (@(posedge sys_clk) $rose(nrst) |->
    (pin_direction_reg == (pio_pkg::DIR_RESET & IMPL_MASK))) else $error("dir not input");
  AST_PERIPH_OWNS: assert property (@(posedge sys_clk) disable iff (!nrst)
    (periph_enable & periph_drive & IMPL_MASK) != 0 |=> ((pad_oe &
    $past(periph_enable & periph_drive & IMPL_MASK)) ==
    $past(periph_enable & periph_drive & IMPL_MASK))) else $error("periph lost pad");
  AST_PORT_DRIVES: assert property (@(posedge sys_clk) disable iff (!nrst)
    1'b1 |=> ((pad_oe & ~$past(periph_enable & periph_drive)) ==
    (~$past(pin_direction_reg) & ~$past(periph_enable & periph_drive) & IMPL_MASK)))
    else $error("port oe wrong");
  AST_DIR_MEANING: assert property (@(posedge sys_clk) disable iff (!nrst)
    ((periph_drive | periph_enable) == 0) |=> (pad_oe == (~$past(pin_direction_reg) & IMPL_MASK)))
    else $error("direction sense");
  AST_LATCH_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
    take && avs_write && avs_address == pio_pkg::LEVEL_OFFSET && avs_byteenable == 4'hf
    |=> output_latch_reg == ($past(wdata) & IMPL_MASK)) else $error("level write lost");
  AST_LATCH_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
    avs_read && bus_state == BUS_IDLE && avs_address == pio_pkg::LATCH_OFFSET
    |=> avs_readdata[pio_pkg::PORT_WIDTH-1:0] == $past(output_latch_reg)) else $error("latch read");
  AST_UNIMPL_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
    ((pin_direction_reg | output_latch_reg | pin_level_reg | pad_oe) & ~IMPL_MASK) == 0)
    else $error("unimplemented bit set");
  AST_ANALOG_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
    1'b1 |=> (pin_level_reg & $past(analog_pin_select_reg)) == 0) else $error("analog pin read");
  AST_LEVEL_LATENCY: assert property (@(posedge sys_clk) disable iff (!nrst)
    1'b1 |=> pin_level_reg == ($past(pad_sync & ~analog_pin_select_reg) & IMPL_MASK))
    else $error("level path");
  AST_CONVERTER_SEL: assert property (@(posedge sys_clk) disable iff (!nrst)
    1'b1 |=> analog_input_pins == ($past(analog_pin_select_reg) & IMPL_MASK))
    else $error("converter select");
endmodule

// ### testbench/pad_model.sv
`timescale 1ns/1ps
module pad_model (
  // Port side of the pads
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe,
  // Board side
  input wire logic [15:0] ext_level,
  output logic [15:0] pad_in
);
  // A driven pad shows its own level; an undriven one shows the board level.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

// ### testbench/tb_shared_parallel_io_port.sv
`timescale 1ns/1ps
module tb_shared_parallel_io_port;
  localparam logic [15:0] IMPL = pio_pkg::IMPL_MASK_DEFAULT;
  localparam logic [3:0] A_DIR = pio_pkg::DIR_OFFSET;
  localparam logic [3:0] A_LVL = pio_pkg::LEVEL_OFFSET;
  localparam logic [3:0] A_LAT = pio_pkg::LATCH_OFFSET;
  localparam logic [3:0] A_ANA = pio_pkg::ANALOG_OFFSET;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] periph_enable = 16'h0;
  logic [15:0] periph_drive = 16'h0;
  logic [15:0] periph_data = 16'h0;
  logic [15:0] ext_level = 16'h0;
  logic [15:0] periph_in, pad_in, pad_out, pad_oe, analog_input_pins;
  logic [31:0] exp_q[$];
  int mismatches = 0;
  int cmp_count = 0;
  logic [15:0] lat, v, e;

  always #50 sys_clk = ~sys_clk;

  shared_parallel_io_port dut_u (.sys_clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .periph_enable,
    .periph_drive, .periph_data, .periph_in, .pad_in, .pad_out, .pad_oe, .analog_input_pins);
  pad_model pad_u (.pad_out, .pad_oe, .ext_level, .pad_in);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // The request is held until waitrequest is seen low, then one idle edge follows.
  task automatic access(input logic [3:0] a, input logic wr, input logic [15:0] d,
    input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {16'h0, d};
    avs_byteenable <= be;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      mismatches++;
      complete_run();
    end
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] x);
    exp_q.push_back({16'h0, x});
    access(a, 1'b0, 16'h0, 4'hf);
  endtask

  always @(posedge sys_clk)
    if (avs_read && avs_waitrequest === 1'b0)
    begin
      if (exp_q.size() == 0)
        check(32'h1, 32'h0);
      else
        check(avs_readdata, exp_q.pop_front());
    end

  initial
  begin
    void'($urandom(76));
    e = 16'($urandom());
    ext_level <= e;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    check(pad_oe, 16'h0);
    rd(A_DIR, pio_pkg::DIR_RESET & IMPL);
    rd(A_LAT, 16'h0);
    rd(4'h2, 16'h0);
    lat = 16'($urandom());
    access(A_LAT, 1'b1, lat, 4'hf);
    rd(A_LAT, lat & IMPL);
    access(A_LAT, 1'b1, 16'hffff, 4'h1);
    lat = (lat & 16'hff00) | 16'h00ff;
    rd(A_LAT, lat & IMPL);
    lat = 16'($urandom());
    access(A_LVL, 1'b1, lat, 4'hf);
    rd(A_LAT, lat & IMPL);
    access(A_DIR, 1'b1, 16'h0, 4'hf);
    repeat (6) @(posedge sys_clk);
    check(pad_oe, IMPL);
    check(pad_out, lat & IMPL);
    rd(A_LVL, lat & IMPL);
    v = 16'($urandom());
    periph_enable <= 16'hffff;
    periph_drive <= 16'h00ff;
    periph_data <= v;
    repeat (2) @(posedge sys_clk);
    check(pad_oe, IMPL);
    check(pad_out, ((v & 16'h00ff) | (lat & 16'hff00)) & IMPL);
    access(A_DIR, 1'b1, 16'hffff, 4'hf);
    repeat (6) @(posedge sys_clk);
    check(pad_oe, 16'h00ff & IMPL);
    check(periph_in, ((v & 16'h00ff) | (e & 16'hff00)) & IMPL);
    rd(A_LVL, ((v & 16'h00ff) | (e & 16'hff00)) & IMPL);
    periph_enable <= 16'h0;
    access(A_ANA, 1'b1, 16'hffff, 4'hf);
    repeat (6) @(posedge sys_clk);
    check(analog_input_pins, 16'h00ff & IMPL);
    rd(A_LVL, e & IMPL & 16'hff00);
    ext_level <= ~e;
    rd(A_LVL, e & IMPL & 16'hff00);
    repeat (6) @(posedge sys_clk);
    rd(A_LVL, ~e & IMPL & 16'hff00);
    access(A_DIR, 1'b1, 16'h0, 4'hf);
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rd(A_DIR, pio_pkg::DIR_RESET & IMPL);
    check(exp_q.size(), 32'h0);
    complete_run();
  end
endmodule
